// [stop_after_start_flag_regs.svh]
// Register offsets, field positions and reset values of the slave status block.
// Assumes byte addresses on an 8-bit register port with 16-bit data.
`ifndef STOP_AFTER_START_FLAG_REGS_SVH
`define STOP_AFTER_START_FLAG_REGS_SVH

`define STOP_AFTER_START_FLAG_OFF_STATUS   8'h00
`define STOP_AFTER_START_FLAG_OFF_CTRL     8'h04
`define STOP_AFTER_START_FLAG_OFF_SLOT0    8'h08
`define STOP_AFTER_START_FLAG_OFF_ALT      8'h18
`define STOP_AFTER_START_FLAG_OFF_RXDATA   8'h1C

`define STOP_AFTER_START_FLAG_CTRL_EN      0
`define STOP_AFTER_START_FLAG_CTRL_GCEN    2
`define STOP_AFTER_START_FLAG_CTRL_HGCEN   3
`define STOP_AFTER_START_FLAG_CTRL_SSIE    8
`define STOP_AFTER_START_FLAG_CTRL_GCCLR   9

`define STOP_AFTER_START_FLAG_STA_ACTIVE   14
`define STOP_AFTER_START_FLAG_STA_REPS     13
`define STOP_AFTER_START_FLAG_STA_IDX_LO   11
`define STOP_AFTER_START_FLAG_STA_SS       10
`define STOP_AFTER_START_FLAG_STA_KIND_LO  8
`define STOP_AFTER_START_FLAG_STA_GC       7

`define STOP_AFTER_START_FLAG_CTRL_RST     16'h0000
`define STOP_AFTER_START_FLAG_SLOT_RST     7'h00
`define STOP_AFTER_START_FLAG_ALT_RST      8'h00
`define STOP_AFTER_START_FLAG_STATUS_RST   16'h0000

`define STOP_AFTER_START_FLAG_START_BYTE   8'h01
`define STOP_AFTER_START_FLAG_GC_ADDR      8'h00
`define STOP_AFTER_START_FLAG_GC_RESET     8'h06
`define STOP_AFTER_START_FLAG_GC_PROG      8'h04

`define STOP_AFTER_START_FLAG_KIND_NONE    2'h0
`define STOP_AFTER_START_FLAG_KIND_RESET   2'h1
`define STOP_AFTER_START_FLAG_KIND_PROG    2'h2
`define STOP_AFTER_START_FLAG_KIND_ALT     2'h3

`endif

// [stop_after_start_flag_pkg.sv]
// Types shared by the slave status block: bus state, register port and full state.
// Assumes constants come from stop_after_start_flag_regs.svh.
package stop_after_start_flag_pkg;

	typedef enum logic [4:0] {
		ST_IDLE   = 5'b00001,
		ST_ADDR   = 5'b00010,
		ST_GCDATA = 5'b00100,
		ST_DATA   = 5'b01000,
		ST_SKIP   = 5'b10000
	} stop_after_start_flag_state_t;

	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [7:0]  addr;
		logic [15:0] wdata;
	} stop_after_start_flag_req_t;

	typedef struct packed {
		logic        scl1;
		logic        scl2;
		logic        scl3;
		logic        sda1;
		logic        sda2;
		logic        sda3;
		stop_after_start_flag_state_t st;
		logic [3:0]  cnt;
		logic [7:0]  shift;
		logic        ack;
		logic [15:0] ctrl;
		logic [3:0][6:0] slot;
		logic [7:0]  alt;
		logic [7:0]  rx;
		logic        active;
		logic        reps;
		logic [1:0]  idx;
		logic        ss;
		logic [1:0]  kind;
		logic        gc;
		logic [15:0] rd_data;
	} stop_after_start_flag_st_t;

endpackage : stop_after_start_flag_pkg

// [stop_after_start_flag_status.sv]
// I2C slave front end with its status flags and a plain register port.
// Assumes SCL and SDA come from pins outside the clock domain; the master drives SCL.
`timescale 1ns/1ns

module stop_after_start_flag_status
	import stop_after_start_flag_pkg::*;
(
	input  wire logic              clk_in,
	input  wire logic              rst_in,
	input  wire stop_after_start_flag_pkg::stop_after_start_flag_req_t req_in,
	output logic      [15:0]       rd_data_out,
	input  wire logic              scl_in,
	input  wire logic              sda_in,
	output logic                   sda_out,
	output logic                   sda_oe_out,
	output logic                   irq_out
);
	import stop_after_start_flag_pkg::*;

	`include "stop_after_start_flag_regs.svh"

	localparam stop_after_start_flag_st_t RST_VAL = '{
		scl1: 1'b1, scl2: 1'b1, scl3: 1'b1,
		sda1: 1'b1, sda2: 1'b1, sda3: 1'b1,
		st: ST_IDLE, ctrl: `STOP_AFTER_START_FLAG_CTRL_RST, alt: `STOP_AFTER_START_FLAG_ALT_RST,
		default: '0
	};

	function automatic logic sel(input stop_after_start_flag_req_t q, input logic [7:0] off);
		sel = (q.addr == off);
	endfunction : sel

	stop_after_start_flag_st_t   r;
	stop_after_start_flag_st_t   n;
	logic [3:0]  slot_hit;
	logic [1:0]  hit_idx;
	logic        scl_rise;
	logic        scl_fall;
	logic        ev_start;
	logic        ev_stop;
	logic        byte_done;
	logic        ev_match;
	logic        ev_sbyte;
	logic        ev_gcaddr;
	logic        gc_set;
	logic        reps_set;
	logic        ss_set;
	logic        reset_if;
	logic        stat_rd;
	logic        gcclr;
	logic [15:0] status_w;

	////////////////////////////////////////////////////////////////////////////////
	// Own-address compare, one comparator per slot.

	generate
		for (genvar i = 0; i < 4; i++) begin : g_slot
			assign slot_hit[i] = (r.shift[7:1] == r.slot[i]);
		end
	endgenerate

	// Lowest slot wins when software programs the same address twice.
	always_comb begin
		hit_idx = 2'h0;
		for (int j = 3; j >= 0; j--) begin
			if (slot_hit[j]) begin
				hit_idx = 2'(j);
			end
		end
	end

	assign status_w = {1'b0, r.active, r.reps, r.idx, r.ss, r.kind, r.gc, 7'h00};

	////////////////////////////////////////////////////////////////////////////////
	// Next state.

	always_comb begin
		n = r;
		n.scl1 = scl_in;
		n.scl2 = r.scl1;
		n.scl3 = r.scl2;
		n.sda1 = sda_in;
		n.sda2 = r.sda1;
		n.sda3 = r.sda2;
		n.rd_data = 16'h0000;
		scl_rise = r.scl2 & ~r.scl3;
		scl_fall = ~r.scl2 & r.scl3;
		ev_start = r.scl2 & r.scl3 & ~r.sda2 & r.sda3;
		ev_stop = r.scl2 & r.scl3 & r.sda2 & ~r.sda3;
		byte_done = r.ctrl[`STOP_AFTER_START_FLAG_CTRL_EN] & ~ev_start & ~ev_stop & scl_fall
			& (r.cnt == 4'h8);
		ev_match = byte_done & (r.st == ST_ADDR) & (|slot_hit);
		ev_sbyte = byte_done & (r.st == ST_ADDR) & ~(|slot_hit)
			& (r.shift == `STOP_AFTER_START_FLAG_START_BYTE);
		ev_gcaddr = byte_done & (r.st == ST_ADDR) & ~(|slot_hit)
			& (r.shift == `STOP_AFTER_START_FLAG_GC_ADDR);
		gc_set = 1'b0;
		reps_set = 1'b0;
		ss_set = 1'b0;
		reset_if = 1'b0;
		stat_rd = req_in.rd & sel(req_in, `STOP_AFTER_START_FLAG_OFF_STATUS);
		gcclr = req_in.wr & sel(req_in, `STOP_AFTER_START_FLAG_OFF_CTRL) & req_in.wdata[`STOP_AFTER_START_FLAG_CTRL_GCCLR];

		if (!r.ctrl[`STOP_AFTER_START_FLAG_CTRL_EN]) begin
			n.st = ST_IDLE;
			// An acknowledge already on the bus is finished at the end of its clock.
			// The reset command turns the slave off while its own byte is acked, and
			// cutting the pulse short would show the master a missing acknowledge.
			n.ack = r.ack & ~scl_fall & ~ev_stop;
			n.cnt = 4'h0;
		end else if (ev_start) begin
			if (r.st != ST_IDLE) begin
				reps_set = 1'b1;
			end
			n.st = ST_ADDR;
			n.cnt = 4'h0;
			n.ack = 1'b0;
		end else if (ev_stop) begin
			ss_set = r.active;
			n.active = 1'b0;
			n.reps = 1'b0;
			n.st = ST_IDLE;
			n.ack = 1'b0;
		end else if (r.st != ST_IDLE) begin
			if (scl_rise && r.cnt < 4'h8) begin
				n.shift = {r.shift[6:0], r.sda2};
				n.cnt = r.cnt + 4'h1;
			end else if (scl_rise) begin
				n.cnt = 4'h9;
			end else if (scl_fall && r.cnt == 4'h9) begin
				n.ack = 1'b0;
				n.cnt = 4'h0;
			end else if (byte_done) begin
				unique case (r.st)
					ST_ADDR: begin
						if (|slot_hit) begin
							n.active = 1'b1;
							n.idx = hit_idx;
							n.ack = 1'b1;
							n.st = r.shift[0] ? ST_SKIP : ST_DATA;
						end else if (r.shift == `STOP_AFTER_START_FLAG_START_BYTE) begin
							n.active = 1'b1;
							n.st = ST_SKIP;
						end else if (r.shift == `STOP_AFTER_START_FLAG_GC_ADDR && r.ctrl[`STOP_AFTER_START_FLAG_CTRL_GCEN]) begin
							n.active = 1'b1;
							n.ack = 1'b1;
							n.st = ST_GCDATA;
						end else begin
							n.st = ST_SKIP;
						end
					end
					ST_GCDATA: begin
						n.ack = 1'b1;
						n.rx = r.shift;
						n.st = ST_DATA;
						if (r.shift == `STOP_AFTER_START_FLAG_GC_RESET) begin
							n.kind = `STOP_AFTER_START_FLAG_KIND_RESET;
							gc_set = 1'b1;
							reset_if = 1'b1;
						end else if (r.shift == `STOP_AFTER_START_FLAG_GC_PROG) begin
							n.kind = `STOP_AFTER_START_FLAG_KIND_PROG;
							gc_set = 1'b1;
						end else if (r.ctrl[`STOP_AFTER_START_FLAG_CTRL_HGCEN] && r.shift == r.alt) begin
							n.kind = `STOP_AFTER_START_FLAG_KIND_ALT;
							gc_set = 1'b1;
						end
					end
					ST_DATA: begin
						n.rx = r.shift;
						n.ack = 1'b1;
					end
					ST_SKIP: begin
						n.ack = 1'b0;
					end
					default: begin
						n.st = ST_IDLE;
					end
				endcase
			end
		end

		// A flag raised in the same cycle as its clear survives the clear.
		n.reps = reps_set | (n.reps & ~stat_rd);
		n.ss = ss_set | (r.ss & ~stat_rd);
		n.gc = gc_set | (r.gc & ~gcclr);
		if (gcclr && !gc_set) begin
			n.kind = `STOP_AFTER_START_FLAG_KIND_NONE;
		end

		if (req_in.rd) begin
			if (sel(req_in, `STOP_AFTER_START_FLAG_OFF_STATUS)) begin
				n.rd_data = status_w;
			end else if (sel(req_in, `STOP_AFTER_START_FLAG_OFF_CTRL)) begin
				n.rd_data = r.ctrl;
			end else if (sel(req_in, `STOP_AFTER_START_FLAG_OFF_ALT)) begin
				n.rd_data = {8'h00, r.alt};
			end else if (sel(req_in, `STOP_AFTER_START_FLAG_OFF_RXDATA)) begin
				n.rd_data = {8'h00, r.rx};
			end else begin
				for (int k = 0; k < 4; k++) begin
					if (sel(req_in, 8'(`STOP_AFTER_START_FLAG_OFF_SLOT0 + 4 * k))) begin
						n.rd_data = {9'h000, r.slot[k]};
					end
				end
			end
		end

		// Status writes fall through every decode and change nothing.
		if (req_in.wr) begin
			if (sel(req_in, `STOP_AFTER_START_FLAG_OFF_CTRL)) begin
				n.ctrl = req_in.wdata;
				n.ctrl[`STOP_AFTER_START_FLAG_CTRL_GCCLR] = 1'b0;
			end else if (sel(req_in, `STOP_AFTER_START_FLAG_OFF_ALT)) begin
				n.alt = req_in.wdata[7:0];
			end else begin
				for (int k = 0; k < 4; k++) begin
					if (sel(req_in, 8'(`STOP_AFTER_START_FLAG_OFF_SLOT0 + 4 * k))) begin
						n.slot[k] = req_in.wdata[6:0];
					end
				end
			end
		end

		// The reset command keeps the bus engine, the kind field and the call flag,
		// so the master still sees its acknowledge and software can see the cause.
		if (reset_if) begin
			n.ctrl = `STOP_AFTER_START_FLAG_CTRL_RST;
			n.alt = `STOP_AFTER_START_FLAG_ALT_RST;
			n.slot = {4{`STOP_AFTER_START_FLAG_SLOT_RST}};
			n.active = 1'b0;
			n.reps = 1'b0;
			n.ss = 1'b0;
			n.idx = 2'h0;
			n.ack = 1'b1;
			n.st = ST_DATA;
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			r <= RST_VAL;
		end else begin
			r <= n;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs.

	assign rd_data_out = r.rd_data;
	assign sda_out = 1'b0;
	assign sda_oe_out = r.ack;
	assign irq_out = r.ss & r.ctrl[`STOP_AFTER_START_FLAG_CTRL_SSIE];

	////////////////////////////////////////////////////////////////////////////////
	// Checks.

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);

	addr_match_set_a: assert property (ev_match |=> r.active)
		else $error("address match did not set the active flag");
	start_byte_set_a: assert property (ev_sbyte |=> r.active && !sda_oe_out)
		else $error("start byte did not set the active flag");
	gen_call_set_a: assert property (ev_gcaddr && r.ctrl[`STOP_AFTER_START_FLAG_CTRL_GCEN] |=>
		r.active && sda_oe_out)
		else $error("general call address not taken");
	stop_clears_a: assert property (ev_stop && r.ctrl[`STOP_AFTER_START_FLAG_CTRL_EN] |=>
		!r.active && !r.reps)
		else $error("stop did not clear the active flags");
	rep_start_a: assert property (ev_start && r.ctrl[`STOP_AFTER_START_FLAG_CTRL_EN] &&
		r.st != ST_IDLE |=> r.reps ##1 (r.reps || $past(stat_rd) || $past(ev_stop)))
		else $error("repeated start flag not held");
	reps_read_clear_a: assert property (stat_rd && !ev_start |=> !r.reps)
		else $error("status read did not clear repeated start");
	slot_index_a: assert property (ev_match |=> r.idx == $past(hit_idx))
		else $error("matched slot index wrong");
	stop_after_a: assert property (ev_stop && r.ctrl[`STOP_AFTER_START_FLAG_CTRL_EN] && r.active
		|=> r.ss)
		else $error("stop after start not flagged");
	stop_irq_a: assert property (ev_stop && r.ctrl[`STOP_AFTER_START_FLAG_CTRL_EN] && r.active &&
		r.ctrl[`STOP_AFTER_START_FLAG_CTRL_SSIE] && !req_in.wr |=> irq_out)
		else $error("stop interrupt missing");
	ss_read_clear_a: assert property (stat_rd && !ss_set |=> !r.ss && !irq_out)
		else $error("status read did not clear stop flag");
	gc_clear_a: assert property (gcclr && !gc_set |=>
		r.kind == `STOP_AFTER_START_FLAG_KIND_NONE && !r.gc)
		else $error("general call clear failed");
	gc_reset_kind_a: assert property (reset_if |=> r.kind == `STOP_AFTER_START_FLAG_KIND_RESET &&
		r.gc && r.ctrl == `STOP_AFTER_START_FLAG_CTRL_RST)
		else $error("general call reset lost the kind or kept registers");
	read_only_a: assert property (req_in.wr && sel(req_in, `STOP_AFTER_START_FLAG_OFF_STATUS) &&
		!ev_start && !ev_stop && !byte_done |=> $stable(status_w))
		else $error("status write changed the status");
	status_read_a: assert property (stat_rd |=> rd_data_out == $past(status_w))
		else $error("status read data wrong");

	// Command decoding after the call address, and the acknowledge pin.
	gc_flag_set_a: assert property (gc_set |=> r.gc)
		else $error("general call command did not set the call flag");
	gc_prog_kind_a: assert property (byte_done && r.st == ST_GCDATA &&
		r.shift == `STOP_AFTER_START_FLAG_GC_PROG |=> r.kind == `STOP_AFTER_START_FLAG_KIND_PROG && r.gc)
		else $error("program address call not flagged");
	hw_call_rx_a: assert property (byte_done && r.st == ST_GCDATA |=>
		r.rx == $past(r.shift))
		else $error("second call byte not kept");
	alt_match_a: assert property (byte_done && r.st == ST_GCDATA &&
		r.ctrl[`STOP_AFTER_START_FLAG_CTRL_HGCEN] && r.shift == r.alt && r.shift != `STOP_AFTER_START_FLAG_GC_RESET &&
		r.shift != `STOP_AFTER_START_FLAG_GC_PROG |=> r.kind == `STOP_AFTER_START_FLAG_KIND_ALT && r.gc)
		else $error("alternate identifier call not flagged");
	reset_ack_a: assert property (reset_if |=> sda_oe_out ##1 sda_oe_out)
		else $error("reset command acknowledge cut short");
	ack_release_a: assert property (sda_oe_out && scl_fall && r.cnt == 4'h9 &&
		r.ctrl[`STOP_AFTER_START_FLAG_CTRL_EN] |=> !sda_oe_out)
		else $error("acknowledge held past its clock");
	disabled_quiet_a: assert property (!r.ctrl[`STOP_AFTER_START_FLAG_CTRL_EN] && !sda_oe_out |=>
		!sda_oe_out && $stable(r.active))
		else $error("disabled slave reacted to the bus");

	match_c: cover property (ev_match ##[1:1000] ev_stop);
	gc_reset_c: cover property (reset_if);
	hw_gc_c: cover property (gc_set && n.kind == `STOP_AFTER_START_FLAG_KIND_ALT);
	rep_start_c: cover property (reps_set);
	start_byte_c: cover property (ev_sbyte);

endmodule : stop_after_start_flag_status

// [stop_after_start_flag_master.sv]
// Behavioural I2C bus master that drives the slave status block from outside.
// Assumes the bench resolves open-drain SDA with a pull-up; SCL idles high.
`timescale 1ns/1ns

module stop_after_start_flag_master (
	output logic      scl_out,
	output logic      sda_low_out,
	input  wire logic sda_in
);
	localparam int Q = 40;

	initial begin
		scl_out = 1'b1;
		sda_low_out = 1'b0;
	end

	// Pins change by non-blocking assignment, since the steps land on clock edges.
	// Called with SCL low this gives a repeated start.
	task automatic start();
		sda_low_out <= 1'b0;
		#Q scl_out <= 1'b1;
		#Q sda_low_out <= 1'b1;
		#Q scl_out <= 1'b0;
		#Q;
	endtask : start

	task automatic put(input logic [7:0] b, output logic ack);
		for (int i = 7; i >= 0; i--) begin
			sda_low_out <= ~b[i];
			#Q scl_out <= 1'b1;
			#(2 * Q) scl_out <= 1'b0;
			#Q;
		end
		sda_low_out <= 1'b0;
		#Q scl_out <= 1'b1;
		#Q ack = ~sda_in;
		#Q scl_out <= 1'b0;
		#Q;
	endtask : put

	// The long tail leaves the slave time to settle its flags.
	task automatic stop();
		sda_low_out <= 1'b1;
		#Q scl_out <= 1'b1;
		#Q sda_low_out <= 1'b0;
		#(4 * Q);
	endtask : stop
endmodule : stop_after_start_flag_master

// [test_i2c_slave_status_flags.sv]
// Self-checking bench for the slave status block against a flag model.
// Assumes stop_after_start_flag_master plays the bus master at a 160 ns SCL period.
`timescale 1ns/1ns
`include "stop_after_start_flag_regs.svh"

module test_i2c_slave_status_flags;
	import stop_after_start_flag_pkg::*;

	logic        clk_in = 1'b0;
	logic        rst_in = 1'b1;
	stop_after_start_flag_req_t  req = '0;
	logic [15:0] rd_data;
	logic        sda_oe;
	logic        sda_o;
	logic        irq;
	logic        scl;
	logic        m_low;
	logic        ack;
	wire         sda = ~(m_low | (sda_oe & ~sda_o));
	int          failures = 0;
	int          checks = 0;
	int          active = 0, reps = 0, idx = 0, ss = 0, kind = 0, gc = 0;
	logic [7:0]  rxq[$];
	logic [31:0] seed = 32'h00005B7C;

	stop_after_start_flag_status stop_after_start_flag_status_i (.clk_in(clk_in), .rst_in(rst_in), .req_in(req),
		.rd_data_out(rd_data), .scl_in(scl), .sda_in(sda), .sda_out(sda_o),
		.sda_oe_out(sda_oe), .irq_out(irq));
	stop_after_start_flag_master stop_after_start_flag_master_i (.scl_out(scl), .sda_low_out(m_low), .sda_in(sda));

	always #4 clk_in = ~clk_in;

	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [7:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction : rnd

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %0t reg got %h exp %h", $time, got, exp);
		end
	endtask : chk

	task automatic chk1(input logic got, input logic exp);
		checks++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %0t pin got %b exp %b", $time, got, exp);
		end
	endtask : chk1

	// Each access waits for an edge of its own first: the bus model returns on
	// clock edges, and a strobe raised in that same step would race the edge.
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk_in);
		req.wr <= 1'b1;
		req.addr <= a;
		req.wdata <= d;
		@(posedge clk_in);
		req.wr <= 1'b0;
		@(posedge clk_in);
	endtask : wr

	// Read data stand for the one cycle after the strobe and are taken at its end.
	task automatic rd(input logic [7:0] a, output logic [15:0] d);
		@(posedge clk_in);
		req.rd <= 1'b1;
		req.addr <= a;
		@(posedge clk_in);
		req.rd <= 1'b0;
		@(posedge clk_in);
		d = rd_data;
	endtask : rd

	// A status read clears the read-cleared flags in the model too.
	task automatic rs();
		logic [15:0] d;
		rd(`STOP_AFTER_START_FLAG_OFF_STATUS, d);
		chk(d, 16'(active << 14 | reps << 13 | idx << 11 | ss << 10 | kind << 8 | gc << 7));
		ss = 0;
		reps = 0;
	endtask : rs

	task automatic snd(input logic [7:0] b, input logic e);
		stop_after_start_flag_master_i.put(b, ack);
		chk1(ack, e);
	endtask : snd

	task automatic stp();
		stop_after_start_flag_master_i.stop();
		ss = ss | active;
		active = 0;
		reps = 0;
	endtask : stp

	task automatic setup(input logic [7:0] alt);
		@(posedge clk_in);
		wr(`STOP_AFTER_START_FLAG_OFF_CTRL, 16'h010D);
		wr(`STOP_AFTER_START_FLAG_OFF_ALT, {8'h00, alt});
		for (int s = 0; s < 4; s++) wr(8'(`STOP_AFTER_START_FLAG_OFF_SLOT0 + 4 * s), 16'(16'h0050 + s));
	endtask : setup

	task automatic end_of_test();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : end_of_test

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		logic [7:0]  alt;
		logic [7:0]  b;
		logic [15:0] d;
		repeat (2) @(posedge clk_in);
		rst_in <= 1'b0;
		repeat (4) @(posedge clk_in);
		alt = rnd() | 8'h01;
		setup(alt);
		stop_after_start_flag_master_i.start();
		snd(8'h00, 1'b1);
		snd(8'h04, 1'b1);
		active = 1;
		kind = 2;
		gc = 1;
		rs();
		stp();
		rs();
		rs();
		wr(`STOP_AFTER_START_FLAG_OFF_CTRL, 16'h030D);
		kind = 0;
		gc = 0;
		rs();
		stop_after_start_flag_master_i.start();
		snd(8'h00, 1'b1);
		snd(alt, 1'b1);
		kind = 3;
		gc = 1;
		active = 1;
		rxq.push_back(alt);
		stp();
		rs();
		rd(`STOP_AFTER_START_FLAG_OFF_RXDATA, d);
		chk(d, {8'h00, rxq[$]});
		$display("general call program and alternate done");
		stop_after_start_flag_master_i.start();
		snd(8'h00, 1'b1);
		snd(8'h06, 1'b1);
		kind = 1;
		gc = 1;
		active = 0;
		ss = 0;
		idx = 0;
		stop_after_start_flag_master_i.stop();
		rs();
		rd(`STOP_AFTER_START_FLAG_OFF_CTRL, d);
		chk(d, 16'h0000);
		rd(`STOP_AFTER_START_FLAG_OFF_SLOT0, d);
		chk(d, 16'h0000);
		$display("general call reset done");
		setup(alt);
		wr(`STOP_AFTER_START_FLAG_OFF_CTRL, 16'h030D);
		kind = 0;
		gc = 0;
		for (int s = 0; s < 4; s++) begin
			b = rnd();
			stop_after_start_flag_master_i.start();
			snd({7'(7'h50 + s), 1'b0}, 1'b1);
			active = 1;
			idx = s;
			rs();
			if (s >= 2) begin
				stop_after_start_flag_master_i.start();
				snd({7'(7'h50 + s), 1'b0}, 1'b1);
				reps = 1;
				if (s == 2) begin
					rs();
					rs();
				end
			end
			snd(b, 1'b1);
			rxq.push_back(b);
			stp();
			chk1(irq, 1'b1);
			rs();
			chk1(irq, 1'b0);
			rd(`STOP_AFTER_START_FLAG_OFF_RXDATA, d);
			chk(d, {8'h00, rxq[$]});
		end
		$display("slot match done");
		stop_after_start_flag_master_i.start();
		snd(`STOP_AFTER_START_FLAG_START_BYTE, 1'b0);
		active = 1;
		rs();
		stp();
		wr(`STOP_AFTER_START_FLAG_OFF_STATUS, 16'hFFFF);
		rs();
		rs();
		rd(8'h40, d);
		chk(d, 16'h0000);
		$display("start byte and read only done");
		end_of_test();
	end

	// Whole run needs about 30 us; eight times that means a hang.
	initial begin
		#240000;
		failures++;
		$display("[FAIL] %0t watchdog expired", $time);
		end_of_test();
	end
endmodule : test_i2c_slave_status_flags
